// File: odc_params.svh
// Purpose: constants of the output divider configuration block
// Assumes: 8-bit register port, one register per address
// Notes:   values are shared by the design and its checks
`ifndef ODC_PARAMS_SVH
`define ODC_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ODC_HS_CTRL_OFS   8'h19
`define ODC_LS1_TOP_OFS   8'h1F
`define ODC_LS1_MID_OFS   8'h20
`define ODC_ALARM_MSK_OFS 8'h17
`define ODC_ALARM_FLG_OFS 8'h84

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ODC_HS_CODE_MSB   7
`define ODC_HS_CODE_LSB   5
`define ODC_LS_TOP_MSB    3
`define ODC_LOCK_BIT      0

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define ODC_HS_CTRL_RST   8'h20
`define ODC_LS1_TOP_RST   8'h00
`define ODC_LS1_MID_RST   8'h00
`define ODC_MASK_RST      1'b1
`define ODC_HS_BASE       4'h4
`define ODC_SYNC_STAGES   2

`endif

// File: odc_pkg.sv
// Purpose: types of the output divider configuration block
// Assumes: constants come from odc_params.svh
// Notes:   types only
package odc_pkg;
   typedef logic [7:0]  odc_byte_t;
   typedef logic [3:0]  odc_hs_ratio_t;
   typedef logic [20:0] odc_ls_ratio_t;
endpackage : odc_pkg

// File: odc_output_divider_config.sv
// Purpose: register file and divider chain for the shared high-speed divider
//          and the first output's low-speed divider, plus lock-loss masking
// Assumes: register port is driven by the serial control port logic on i_clock
// Notes:   low byte of the first output divider arrives from its own register
//
// Overview of operation
// RL1: mask bit gates lock-loss flag onto interrupt
// RL2: mask writes never alter the lock-loss flag
// RL3: code bits 7:5 select divide 4 to 11
// RL4: high-speed divider clocks the first output's low-speed divider
// RL5: 20-bit field: top nibble, then mid byte
// RL6: software writes only zero or odd fields
// RL7: low-speed divider ratio is field plus one
// RL8: high-speed control register resets to 0x20
// RL9: middle divider byte resets to zero
// RL10: mask zero passes alarm when pin enabled
// RL11: reserved bits read zero, ignore writes
// RL12: lock-loss mask: zero enables, one suppresses
`timescale 1ns/100ps
`include "odc_params.svh"

module odc_output_divider_config
   import odc_pkg::*;
(
   // clock, reset, enable
   input  wire logic          i_clock,
   input  wire logic          i_rst_b,
   input  wire logic          i_clk_en,
   // register port
   input  wire logic          i_reg_wr,
   input  wire logic          i_reg_rd,
   input  wire odc_byte_t     i_reg_addr,
   input  wire odc_byte_t     i_reg_wdata,
   output odc_byte_t          o_reg_rdata,
   // alarm side
   input  wire logic          i_lock_loss,
   input  wire logic          i_int_pin_en,
   output logic               o_interrupt_output_pin,
   // divider chain
   input  wire odc_byte_t     i_lowspeed_low_byte,
   output odc_hs_ratio_t      o_highspeed_ratio,
   output odc_ls_ratio_t      o_first_lowspeed_ratio,
   output logic               o_highspeed_tick,
   output logic               o_first_clock_output_tick
);

   // ----------------------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------------------
   // code 000 selects 4, each step adds one
   function automatic odc_hs_ratio_t hs_ratio_f(input logic [2:0] code);
      hs_ratio_f = `ODC_HS_BASE + {1'b0, code};
   endfunction : hs_ratio_f

   function automatic logic wr_hit_f(input logic wr, input odc_byte_t addr, input odc_byte_t ofs);
      wr_hit_f = wr && (addr == ofs);
   endfunction : wr_hit_f

   logic [2:0]    hs_code_r;
   logic [3:0]    ls_top_r;
   odc_byte_t     ls_mid_r;
   logic          mask_r;
   logic          flag_r;
   logic [`ODC_SYNC_STAGES-1:0] lol_sync_r;
   odc_hs_ratio_t hs_cnt_r;
   odc_ls_ratio_t ls_cnt_r;
   logic [19:0]   ls_field;
   odc_byte_t     rd_nxt;

   // ----------------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------------
   // only defined fields are stored, so reserved bits cannot hold state
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hs_code_r <= 3'h1;                        // RL8
         ls_top_r  <= 4'h0;
         ls_mid_r  <= `ODC_LS1_MID_RST;            // RL9
         mask_r    <= `ODC_MASK_RST;
      end else if (i_clk_en) begin
         if (wr_hit_f(i_reg_wr, i_reg_addr, `ODC_HS_CTRL_OFS)) begin
            hs_code_r <= i_reg_wdata[`ODC_HS_CODE_MSB:`ODC_HS_CODE_LSB]; // RL3 RL11
         end
         if (wr_hit_f(i_reg_wr, i_reg_addr, `ODC_LS1_TOP_OFS)) begin
            ls_top_r <= i_reg_wdata[`ODC_LS_TOP_MSB:0]; // RL5 RL11
         end
         if (wr_hit_f(i_reg_wr, i_reg_addr, `ODC_LS1_MID_OFS)) begin
            ls_mid_r <= i_reg_wdata;                   // RL5
         end
         if (wr_hit_f(i_reg_wr, i_reg_addr, `ODC_ALARM_MSK_OFS)) begin
            mask_r <= i_reg_wdata[`ODC_LOCK_BIT];      // RL12
         end
      end
   end

   // ----------------------------------------------------------------------------
   // lock-loss flag
   // ----------------------------------------------------------------------------
   // lock detector lives in another domain, so two flops first
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lol_sync_r <= '0;
      end else if (i_clk_en) begin
         lol_sync_r <= {lol_sync_r[0], i_lock_loss};
      end
   end

   // sticky; write one to the flag register clears it, a new event wins
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flag_r <= 1'b0;
      end else if (i_clk_en) begin
         if (lol_sync_r[1]) begin
            flag_r <= 1'b1;
         end else if (wr_hit_f(i_reg_wr, i_reg_addr, `ODC_ALARM_FLG_OFS) && i_reg_wdata[`ODC_LOCK_BIT]) begin
            flag_r <= 1'b0;                         // RL2
         end
      end
   end

   // registered pin so it never glitches while mask and flag change
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_interrupt_output_pin <= 1'b0;
      end else if (i_clk_en) begin
         o_interrupt_output_pin <= flag_r && !mask_r && i_int_pin_en; // RL1 RL10 RL12
      end
   end

   // ----------------------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------------------
   always_comb begin
      rd_nxt = 8'h00;                              // unmapped reads zero
      case (i_reg_addr)
         `ODC_HS_CTRL_OFS:   rd_nxt = {hs_code_r, 5'h00};  // RL11
         `ODC_LS1_TOP_OFS:   rd_nxt = {4'h0, ls_top_r};    // RL11
         `ODC_LS1_MID_OFS:   rd_nxt = ls_mid_r;
         `ODC_ALARM_MSK_OFS: rd_nxt = {7'h00, mask_r};
         `ODC_ALARM_FLG_OFS: rd_nxt = {7'h00, flag_r};
         default:            rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reg_rdata <= 8'h00;
      end else if (i_clk_en && i_reg_rd) begin
         o_reg_rdata <= rd_nxt;
      end
   end

   // ----------------------------------------------------------------------------
   // divider chain
   // ----------------------------------------------------------------------------
   assign ls_field = {ls_top_r, ls_mid_r, i_lowspeed_low_byte}; // RL5

   // decoded ratios from flops; software keeps the field zero or odd
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_highspeed_ratio      <= 4'h5;
         o_first_lowspeed_ratio <= 21'h00_0001;
      end else if (i_clk_en) begin
         o_highspeed_ratio      <= hs_ratio_f(hs_code_r);   // RL3
         o_first_lowspeed_ratio <= {1'b0, ls_field} + 21'h00_0001; // RL7 RL6
      end
   end

   // high-speed stage; >= guards against a ratio lowered mid-count
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hs_cnt_r         <= 4'h0;
         o_highspeed_tick <= 1'b0;
      end else if (i_clk_en) begin
         if (hs_cnt_r >= hs_ratio_f(hs_code_r) - 4'h1) begin
            hs_cnt_r         <= 4'h0;
            o_highspeed_tick <= 1'b1;
         end else begin
            hs_cnt_r         <= hs_cnt_r + 4'h1;
            o_highspeed_tick <= 1'b0;
         end
      end
   end

   // low-speed stage advances only on high-speed ticks
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ls_cnt_r                  <= 21'h00_0000;
         o_first_clock_output_tick <= 1'b0;
      end else if (i_clk_en) begin
         o_first_clock_output_tick <= 1'b0;
         if (o_highspeed_tick) begin                // RL4
            if (ls_cnt_r >= {1'b0, ls_field}) begin
               ls_cnt_r                  <= 21'h00_0000;
               o_first_clock_output_tick <= 1'b1;   // RL7
            end else begin
               ls_cnt_r <= ls_cnt_r + 21'h00_0001;
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   logic first_r;
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   sequence mask_write_s;
      i_clk_en && wr_hit_f(i_reg_wr, i_reg_addr, `ODC_ALARM_MSK_OFS);
   endsequence

   sequence flag_clear_s;
      i_clk_en && wr_hit_f(i_reg_wr, i_reg_addr, `ODC_ALARM_FLG_OFS) && i_reg_wdata[0] && !lol_sync_r[1];
   endsequence

   mask_gate_a: assert property (i_clk_en |=> o_interrupt_output_pin == $past(flag_r && !mask_r && i_int_pin_en)) // RL1
      else $error("interrupt pin does not follow masked flag");
   // one cycle only: an unmask write lands at the same edge and may raise the pin after it
   mask_polarity_a: assert property (i_clk_en && mask_r |=> !o_interrupt_output_pin) // RL12
      else $error("masked flag reached interrupt pin");
   alarm_pass_a: assert property (i_clk_en && flag_r && !mask_r && i_int_pin_en |=> o_interrupt_output_pin) // RL10
      else $error("unmasked flag failed to raise pin");
   flag_keep_a: assert property (mask_write_s and flag_r |=> flag_r) // RL2
      else $error("mask write disturbed flag");
   flag_clear_a: assert property (flag_clear_s ##1 !lol_sync_r[1] |-> !flag_r) // RL2
      else $error("flag not cleared by its own write");
   hs_decode_a: assert property (i_clk_en |=> o_highspeed_ratio == $past(hs_code_r) + 4'h4) // RL3
      else $error("high-speed ratio decode wrong");
   // rising edge only: a tick frozen by a low enable must not count as a new one
   hs_feeds_ls_a: assert property ($rose(o_first_clock_output_tick) |-> $past(o_highspeed_tick)) // RL4
      else $error("low-speed tick without high-speed tick");
   ls_ratio_a: assert property (i_clk_en |=> o_first_lowspeed_ratio == {1'b0, $past(ls_field)} + 21'h00_0001) // RL7
      else $error("low-speed ratio not field plus one");
   field_join_a: assert property (i_clk_en && wr_hit_f(i_reg_wr, i_reg_addr, `ODC_LS1_TOP_OFS)
                                  |=> ls_field[19:16] == $past(i_reg_wdata[3:0])) // RL5
      else $error("top nibble not placed at bits 19:16");
   hs_reset_a: assert property (first_r |-> {hs_code_r, 5'h00} == `ODC_HS_CTRL_RST) // RL8
      else $error("high-speed control reset value wrong");
   mid_reset_a: assert property (first_r |-> ls_mid_r == 8'h00) // RL9
      else $error("middle byte reset value wrong");
   rsv_zero_a: assert property (i_clk_en && i_reg_rd && i_reg_addr == `ODC_HS_CTRL_OFS
                                |=> o_reg_rdata == {$past(hs_code_r), 5'h00}) // RL11
      else $error("reserved bits not zero on read");

endmodule : odc_output_divider_config

// File: odc_output_divider_config_test.sv
// Purpose: self-checking bench for the output divider configuration block
// Assumes: strobes last one cycle, inputs change by nba at the rising edge
// Notes:   expectations come from the code and field rules, never from outputs
`timescale 1ns/100ps
`include "odc_params.svh"

module odc_output_divider_config_test
   import odc_pkg::*;
   ;
   // ----------------------------------------------------------------------
   // signals and stimulus tables
   // ----------------------------------------------------------------------
   logic          clock;
   logic          rst_b;
   logic          clk_en;
   logic          reg_wr;
   logic          reg_rd;
   odc_byte_t     reg_addr;
   odc_byte_t     reg_wdata;
   odc_byte_t     reg_rdata;
   logic          lock_loss;
   logic          pin_en;
   logic          int_pin;
   odc_byte_t     low_byte;
   odc_hs_ratio_t hs_ratio;
   odc_ls_ratio_t ls_ratio;
   logic          hs_tick;
   logic          ls_tick;
   int            error_cnt;
   int            checks_done;
   // only zero or odd fields, as software must program them
   logic [3:0]    fld_top [5] = '{4'h0, 4'h0, 4'h0, 4'h3, 4'hF};
   odc_byte_t     fld_mid [5] = '{8'h00, 8'h00, 8'h00, 8'hA5, 8'hFF};
   odc_byte_t     fld_low [5] = '{8'h00, 8'h01, 8'h05, 8'h01, 8'hFF};
   odc_ls_ratio_t fld_div [5] = '{21'h0_0001, 21'h0_0002, 21'h0_0006, 21'h3_A502, 21'h10_0000};

   // ----------------------------------------------------------------------
   // design and clock
   // ----------------------------------------------------------------------
   odc_output_divider_config uut (
      .i_clock                   (clock),
      .i_rst_b                   (rst_b),
      .i_clk_en                  (clk_en),
      .i_reg_wr                  (reg_wr),
      .i_reg_rd                  (reg_rd),
      .i_reg_addr                (reg_addr),
      .i_reg_wdata               (reg_wdata),
      .o_reg_rdata               (reg_rdata),
      .i_lock_loss               (lock_loss),
      .i_int_pin_en              (pin_en),
      .o_interrupt_output_pin    (int_pin),
      .i_lowspeed_low_byte       (low_byte),
      .o_highspeed_ratio         (hs_ratio),
      .o_first_lowspeed_ratio    (ls_ratio),
      .o_highspeed_tick          (hs_tick),
      .o_first_clock_output_tick (ls_tick)
   );

   // 200 MHz clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // ----------------------------------------------------------------------
   // access, compare and closing tasks
   // ----------------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk_reg(input string name, input odc_byte_t exp, input odc_byte_t got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_reg

   task automatic chk_out(input string name, input odc_ls_ratio_t exp, input odc_ls_ratio_t got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_out

   task automatic chk_bit(input string name, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit

   // strobe held for exactly the one edge that takes it
   task automatic wr_reg(input odc_byte_t addr, input odc_byte_t data);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= addr;
      reg_wdata <= data;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask : wr_reg

   // read data is registered: settled just after the taking edge
   task automatic rd_chk(input odc_byte_t addr, input odc_byte_t exp, input string name);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= addr;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1;
      chk_reg(name, exp, reg_rdata);
   endtask : rd_chk

   // bounded wait for the next tick; a hang ends the run as a mismatch
   task automatic wait_tick(input logic use_ls, output int n);
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while ((use_ls ? ls_tick : hs_tick) !== 1'b1 && n < 4000);
      if (n >= 4000) begin
         error_cnt++;
         report_and_stop();
      end
   endtask : wait_tick

   // two gaps discarded: a ratio change may land mid-count
   task automatic tick_gap(input logic use_ls, input int exp, input string name);
      int n;
      wait_tick(use_ls, n);
      wait_tick(use_ls, n);
      wait_tick(use_ls, n);
      chk_out(name, odc_ls_ratio_t'(exp), odc_ls_ratio_t'(n));
   endtask : tick_gap

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      rst_b = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
      reg_wdata = 8'h00; lock_loss = 1'b0; pin_en = 1'b1; low_byte = 8'h00;
      error_cnt = 0;
      checks_done = 0;
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
      #1;
      chk_out("hs ratio at reset", 21'h0_0005, 21'(hs_ratio));
      rd_chk(`ODC_HS_CTRL_OFS, 8'h20, "hs ctrl reset");
      rd_chk(`ODC_LS1_MID_OFS, 8'h00, "ls mid reset");
      // every code, reserved bits written as ones
      for (int c = 0; c < 8; c++) begin
         wr_reg(`ODC_HS_CTRL_OFS, {c[2:0], 5'h1F});
         rd_chk(`ODC_HS_CTRL_OFS, {c[2:0], 5'h00}, "hs ctrl code");
         chk_out("hs ratio", 21'(c + 4), 21'(hs_ratio));
         tick_gap(1'b0, c + 4, "hs tick gap");
      end
      wr_reg(`ODC_HS_CTRL_OFS, 8'h00);
      // field split over two registers plus the low byte input
      for (int i = 0; i < 5; i++) begin
         @(posedge clock);
         low_byte <= fld_low[i];
         wr_reg(`ODC_LS1_TOP_OFS, {4'hC, fld_top[i]});
         wr_reg(`ODC_LS1_MID_OFS, fld_mid[i]);
         rd_chk(`ODC_LS1_TOP_OFS, {4'h0, fld_top[i]}, "ls top");
         rd_chk(`ODC_LS1_MID_OFS, fld_mid[i], "ls mid");
         chk_out("ls ratio", fld_div[i], ls_ratio);
         if (i < 3) begin
            tick_gap(1'b1, 4 * int'(fld_div[i]), "ls tick gap");
         end
      end
      // a write with the clock enable low is ignored
      @(posedge clock);
      clk_en <= 1'b0;
      wr_reg(`ODC_LS1_MID_OFS, 8'h3C);
      @(posedge clock);
      clk_en <= 1'b1;
      rd_chk(`ODC_LS1_MID_OFS, 8'hFF, "mid while frozen");
      wr_reg(8'h55, 8'hA5);
      rd_chk(8'h55, 8'h00, "unmapped");
      // lock loss: masked at reset, then unmasked, mode off, remasked
      @(posedge clock);
      lock_loss <= 1'b1;
      repeat (6) @(posedge clock);
      #1;
      chk_bit("pin masked", 1'b0, int_pin);
      rd_chk(`ODC_ALARM_FLG_OFS, 8'h01, "flag set");
      wr_reg(`ODC_ALARM_MSK_OFS, 8'h00);
      rd_chk(`ODC_ALARM_FLG_OFS, 8'h01, "flag after unmask");
      chk_bit("pin unmasked", 1'b1, int_pin);
      @(posedge clock);
      pin_en <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk_bit("pin mode off", 1'b0, int_pin);
      @(posedge clock);
      pin_en <= 1'b1;
      wr_reg(`ODC_ALARM_MSK_OFS, 8'h01);
      rd_chk(`ODC_ALARM_FLG_OFS, 8'h01, "flag after remask");
      chk_bit("pin remasked", 1'b0, int_pin);
      // clear only once the loss has gone, then unmask again
      @(posedge clock);
      lock_loss <= 1'b0;
      repeat (4) @(posedge clock);
      wr_reg(`ODC_ALARM_FLG_OFS, 8'h01);
      rd_chk(`ODC_ALARM_FLG_OFS, 8'h00, "flag cleared");
      wr_reg(`ODC_ALARM_MSK_OFS, 8'h00);
      rd_chk(`ODC_ALARM_FLG_OFS, 8'h00, "flag stays clear");
      chk_bit("pin no flag", 1'b0, int_pin);
      report_and_stop();
   end
endmodule : odc_output_divider_config_test
